//--- design/read_out_pipe.sv
// module: read latency shift line driving the data pins
`timescale 1ns/1ps
module read_out_pipe
  import sdram_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  read_pipe_if.pipe                 rp,
  output logic [sdram_pkg::DATA_BITS-1:0] word_out,
  output logic                      word_valid
);
  import sdram_pkg::*;
  localparam int unsigned DEPTH = 3;
  logic [DEPTH-1:0]     vld;
  logic [DATA_BITS-1:0] dat [DEPTH];
  logic [DEPTH-1:0]     next_vld;
  // -------------------------------------------------------------
  // latency line
  // -------------------------------------------------------------
  // a cut clears words still in flight (write takes the bus)
  always_comb begin
    next_vld = {vld[DEPTH-2:0], rp.push};
    if (rp.cut) begin
      next_vld = '0;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vld <= '0;
    end else begin
      vld <= next_vld;
    end
  end
  always_ff @(posedge clk_sys) begin
    dat[0] <= rp.word;
    dat[1] <= dat[0];
    dat[2] <= dat[1];
  end
  // tap chosen by read latency, 1..3 cycles
  always_comb begin
    unique case (rp.latency)
      2'h1: begin
        word_valid = vld[0];
        word_out = dat[0];
      end
      2'h2: begin
        word_valid = vld[1];
        word_out = dat[1];
      end
      default: begin
        word_valid = vld[2];
        word_out = dat[2];
      end
    endcase
  end
endmodule : read_out_pipe

//--- design/sdram_cmd_core.sv
// module: sdram command core, refresh, activation and read bursts
// Functional notes
// - terminate cuts the latest read burst
// - terminate leaves row open
// - refresh row from internal counter
// - self refresh entered refresh with cke low
// - self refresh internal, minimum row active time
// - automotive grade has no self refresh
// - first word after read latency
// - fixed burst floats, full page wraps
// - write floats data lines
// - address bit selects auto precharge
// - mask bit per byte lane
`timescale 1ns/1ps
module sdram_cmd_core
  import sdram_pkg::*;
#(
  parameter int unsigned NUM_BANKS = 4
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        cke,
  input  wire logic                        cs_n,
  input  wire logic                        ras_n,
  input  wire logic                        cas_n,
  input  wire logic                        we_n,
  input  wire logic [sdram_pkg::BANK_BITS-1:0] bank_sel,
  input  wire logic [sdram_pkg::ROW_BITS-1:0]  addr,
  input  wire logic [sdram_pkg::MASK_BITS-1:0] byte_mask,
  input  wire logic                        automotive_grade,
  input  wire logic [sdram_pkg::DATA_BITS-1:0] array_rdata,
  output logic [sdram_pkg::BANK_BITS-1:0]  array_bank,
  output logic [sdram_pkg::ROW_BITS-1:0]   array_row,
  output logic [sdram_pkg::COL_BITS-1:0]   array_col,
  output logic                             refresh_pulse,
  output logic [sdram_pkg::ROW_BITS-1:0]   refresh_row,
  output logic [sdram_pkg::DATA_BITS-1:0]  dq_out,
  output logic [sdram_pkg::MASK_BITS-1:0]  dq_oe_n,
  output logic [NUM_BANKS-1:0]             row_open,
  output logic                             self_refresh
);
  import sdram_pkg::*;
  // -------------------------------------------------------------
  // input capture (pins from another clock domain)
  // -------------------------------------------------------------
  logic [ROW_BITS+BANK_BITS+MASK_BITS+5:0] pin_s1;
  logic [ROW_BITS+BANK_BITS+MASK_BITS+5:0] pin_s2;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
    end else begin
      pin_s1 <= {automotive_grade, cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr, byte_mask};
      pin_s2 <= pin_s1;
    end
  end
  logic                 s_auto, s_cke;
  logic                 s_cs_n;
  cmd_t                 s_cmd;
  logic [BANK_BITS-1:0] s_bank;
  logic [ROW_BITS-1:0]  s_addr;
  logic [MASK_BITS-1:0] s_mask;
  assign {s_auto, s_cke, s_cs_n} = pin_s2[ROW_BITS+BANK_BITS+MASK_BITS+5 -: 3];
  assign s_cmd  = cmd_t'(pin_s2[ROW_BITS+BANK_BITS+MASK_BITS+2 -: 3]);
  assign s_bank = pin_s2[ROW_BITS+MASK_BITS +: BANK_BITS];
  assign s_addr = pin_s2[MASK_BITS +: ROW_BITS];
  assign s_mask = pin_s2[MASK_BITS-1:0];
  // command decode is used in several places
  function automatic logic is_cmd(input logic cs_low, input cmd_t c, input cmd_t want);
    return cs_low && (c == want);
  endfunction : is_cmd
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  pwr_t                  pwr, next_pwr;
  logic [NUM_BANKS-1:0]  open_q, next_open;
  logic [ROW_BITS-1:0]   rows [NUM_BANKS];
  logic [ROW_BITS-1:0]   next_rows [NUM_BANKS];
  logic [ROW_BITS-1:0]   rfc, next_rfc;
  logic                  burst_on, next_burst_on;
  logic [BANK_BITS-1:0]  bbank, next_bbank;
  logic [COL_BITS-1:0]   bcol, next_bcol;
  logic [COL_BITS:0]     bleft, next_bleft;
  logic                  bap, next_bap;
  logic [1:0]            latency, next_latency;
  logic [2:0]            blen, next_blen;
  logic [7:0]            sr_cnt, next_sr_cnt;
  logic                  rpulse, next_rpulse;
  logic [MASK_BITS-1:0]  mask_d1, mask_d2;
  logic                  cs_low;
  logic                  push, cut;
  read_pipe_if rp();
  assign cs_low = !s_cs_n;
  // burst length from mode code: 1,2,4,8 or full page
  function automatic logic [COL_BITS:0] burst_len(input logic [2:0] code);
    return (code == BL_FULL_PAGE) ? {1'b1, {COL_BITS{1'b0}}} :
           (COL_BITS+1)'(1 << code[1:0]);
  endfunction : burst_len
  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    next_pwr = pwr;
    next_open = open_q;
    next_rows = rows;
    next_rfc = rfc;
    next_burst_on = burst_on;
    next_bbank = bbank;
    next_bcol = bcol;
    next_bleft = bleft;
    next_bap = bap;
    next_latency = latency;
    next_blen = blen;
    next_sr_cnt = sr_cnt;
    next_rpulse = 1'b0;
    push = 1'b0;
    cut = 1'b0;
    // running burst: one word a cycle, full page wraps at column 0
    if (burst_on && pwr == PWR_NORMAL) begin
      push = 1'b1;
      next_bcol = bcol + 1'b1;
      if (blen != BL_FULL_PAGE) begin
        next_bleft = bleft - 1'b1;
        if (bleft == 1) begin
          next_burst_on = 1'b0;
          if (bap) begin
            next_open[bbank] = 1'b0;
          end
        end
      end
    end
    unique case (pwr)
      PWR_NORMAL: begin
        if (is_cmd(cs_low, s_cmd, CMD_REFRESH)) begin
          // row taken from own counter, address ignored
          next_rfc = rfc + 1'b1;
          next_rpulse = 1'b1;
          // cke low selects self refresh, not on automotive parts
          if (!s_cke && !s_auto) begin
            next_pwr = PWR_SELF;
            next_sr_cnt = '0;
          end
        end else if (is_cmd(cs_low, s_cmd, CMD_ACTIVATE)) begin
          next_open[s_bank] = 1'b1;
          next_rows[s_bank] = s_addr;
        end else if (is_cmd(cs_low, s_cmd, CMD_READ)) begin
          // a new read cuts the previous one, any clock
          next_burst_on = 1'b1;
          next_bbank = s_bank;
          next_bcol = s_addr[COL_BITS-1:0];
          next_bleft = burst_len(blen);
          next_bap = s_addr[AP_BIT] && (blen != BL_FULL_PAGE);
        end else if (is_cmd(cs_low, s_cmd, CMD_WRITE)) begin
          // write stops read output regardless of mask
          next_burst_on = 1'b0;
          cut = 1'b1;
        end else if (is_cmd(cs_low, s_cmd, CMD_TERMINATE)) begin
          // stop the latest burst, row stays open
          next_burst_on = 1'b0;
        end else if (is_cmd(cs_low, s_cmd, CMD_PRECHARGE)) begin
          if (s_addr[AP_BIT]) begin
            next_open = '0;
          end else begin
            next_open[s_bank] = 1'b0;
          end
          if (s_addr[AP_BIT] || s_bank == bbank) begin
            next_burst_on = 1'b0;
          end
        end else if (is_cmd(cs_low, s_cmd, CMD_MODE)) begin
          next_latency = (s_addr[5:4] == 2'h0) ? READ_LATENCY_RESET : s_addr[5:4];
          next_blen = s_addr[2:0];
        end
      end
      PWR_SELF: begin
        // internal refresh timer; all inputs but cke ignored
        next_burst_on = 1'b0;
        next_sr_cnt = (sr_cnt == 8'hFF) ? 8'hE0 : sr_cnt + 1'b1; // wrap keeps timer bits moving
        if (sr_cnt[4:0] == 5'h1F) begin
          next_rfc = rfc + 1'b1;
          next_rpulse = 1'b1;
        end
        if (s_cke && sr_cnt >= 8'(ROW_ACTIVE_CYCLES)) begin
          next_pwr = PWR_NORMAL;
        end
      end
    endcase
  end
  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwr <= PWR_NORMAL;
      open_q <= '0;
      rows <= '{default: '0};
      rfc <= '0;
      burst_on <= 1'b0;
      bbank <= '0;
      bcol <= '0;
      bleft <= '0;
      bap <= 1'b0;
      latency <= READ_LATENCY_RESET;
      blen <= BURST_CODE_RESET;
      sr_cnt <= '0;
      rpulse <= 1'b0;
      mask_d1 <= '1;
      mask_d2 <= '1;
    end else begin
      pwr <= next_pwr;
      open_q <= next_open;
      rows <= next_rows;
      rfc <= next_rfc;
      burst_on <= next_burst_on;
      bbank <= next_bbank;
      bcol <= next_bcol;
      bleft <= next_bleft;
      bap <= next_bap;
      latency <= next_latency;
      blen <= next_blen;
      sr_cnt <= next_sr_cnt;
      rpulse <= next_rpulse;
      mask_d1 <= s_mask; // mask acts two clocks later
      mask_d2 <= mask_d1;
    end
  end
  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  assign rp.push = push;
  assign rp.word = array_rdata;
  assign rp.latency = latency;
  assign rp.cut = cut;
  logic [DATA_BITS-1:0] pword;
  logic                 pvalid;
  read_out_pipe u_pipe (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .rp         (rp.pipe),
    .word_out   (pword),
    .word_valid (pvalid)
  );
  // output registers; one mask bit per byte lane
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dq_out <= '0;
      dq_oe_n <= '1;
      array_bank <= '0;
      array_row <= '0;
      array_col <= '0;
      refresh_pulse <= 1'b0;
      refresh_row <= '0;
      row_open <= '0;
      self_refresh <= 1'b0;
    end else begin
      dq_out <= pword;
      dq_oe_n <= (pvalid && !cut) ? mask_d2 : '1;
      array_bank <= next_bbank; // address leads so the array word meets its push
      array_row <= next_rows[next_bbank];
      array_col <= next_bcol;
      refresh_pulse <= rpulse;
      refresh_row <= rfc;
      row_open <= open_q;
      self_refresh <= (pwr == PWR_SELF);
    end
  end
  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  term_stops_a: assert property ((cs_low && s_cmd == CMD_TERMINATE && pwr == PWR_NORMAL)
    |=> !burst_on) else $error("burst continued after terminate");
  term_keeps_row_a: assert property ((cs_low && s_cmd == CMD_TERMINATE && pwr == PWR_NORMAL)
    |=> open_q == $past(open_q)) else $error("terminate changed open rows");
  refresh_count_a: assert property ((cs_low && s_cmd == CMD_REFRESH && pwr == PWR_NORMAL)
    |=> rfc == $past(rfc) + 1'b1) else $error("refresh counter not advanced");
  self_entry_a: assert property ((cs_low && s_cmd == CMD_REFRESH && !s_cke && !s_auto
    && pwr == PWR_NORMAL) |=> pwr == PWR_SELF) else $error("self refresh not entered");
  self_min_a: assert property ((pwr == PWR_SELF && $past(pwr) == PWR_NORMAL)
    |-> pwr == PWR_SELF [*8]) else $error("self refresh left too early");
  auto_no_self_a: assert property (s_auto && pwr == PWR_NORMAL |=> pwr == PWR_NORMAL)
    else $error("automotive part entered self refresh");
  write_floats_a: assert property ((cs_low && s_cmd == CMD_WRITE && pwr == PWR_NORMAL)
    |=> ##1 dq_oe_n == '1) else $error("data driven after write");
  read_latency_a: assert property ((cs_low && s_cmd == CMD_READ && pwr == PWR_NORMAL
    && latency == 2'h3) ##1 (!cut && burst_on) [*4] |-> ##1 pvalid)
    else $error("read word late");
  cover_read_c: cover property (cs_low && s_cmd == CMD_READ ##[1:6] !dq_oe_n[0]);
  cover_self_c: cover property (pwr == PWR_SELF ##[1:300] pwr == PWR_NORMAL);
  cover_term_c: cover property (burst_on ##1 cs_low && s_cmd == CMD_TERMINATE);
endmodule : sdram_cmd_core

//--- pkg/read_pipe_if.sv
// interface: read data path between the command core and the output pipe
`timescale 1ns/1ps
interface read_pipe_if;
  import sdram_pkg::*;
  logic                 push;
  logic [DATA_BITS-1:0] word;
  logic [1:0]           latency;
  logic                 cut;
  modport core (output push, output word, output latency, output cut);
  modport pipe (input push, input word, input latency, input cut);
endinterface : read_pipe_if

//--- pkg/sdram_pkg.sv
// package: command codes, geometry, timing constants for the sdram command core
package sdram_pkg;
  localparam int unsigned CLK_PERIOD_PS        = 5000;
  localparam int unsigned ROW_BITS             = 12;
  localparam int unsigned COL_BITS             = 8;
  localparam int unsigned BANK_BITS            = 2;
  localparam int unsigned DATA_BITS            = 32;
  localparam int unsigned MASK_BITS            = 4;
  localparam int unsigned AP_BIT               = 10;   // auto_precharge_select_bit position
  localparam int unsigned MASK_READ_LATENCY    = 2;
  localparam int unsigned ROW_ACTIVE_TIME_PS   = 42000;
  localparam int unsigned ROW_ACTIVE_CYCLES    =
    (ROW_ACTIVE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0]  BL_FULL_PAGE         = 3'h7;
  localparam logic [1:0]  READ_LATENCY_RESET   = 2'h3;
  localparam logic [2:0]  BURST_CODE_RESET     = 3'h2;
  // {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_ACTIVATE  = 3'b011,
    CMD_READ      = 3'b101,
    CMD_WRITE     = 3'b100,
    CMD_TERMINATE = 3'b110,
    CMD_PRECHARGE = 3'b010,
    CMD_REFRESH   = 3'b001,
    CMD_MODE      = 3'b000,
    CMD_NOP       = 3'b111
  } cmd_t;
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SELF   = 2'b01
  } pwr_t;
endpackage : sdram_pkg

//--- verification/array_model.sv
// array model: answers each burst address with a word that encodes it
`timescale 1ns/1ps
module array_model (
  input  wire logic [sdram_pkg::BANK_BITS-1:0] array_bank,
  input  wire logic [sdram_pkg::ROW_BITS-1:0]  array_row,
  input  wire logic [sdram_pkg::COL_BITS-1:0]  array_col,
  output logic [sdram_pkg::DATA_BITS-1:0]      array_rdata
);
  import sdram_pkg::*;
  // ------------------------------------------------------------
  // storage stand-in
  // ------------------------------------------------------------
  // address-tagged data lets the bench see order and wrap of columns
  assign array_rdata = {6'h00, array_bank, array_row, array_col, 4'h0};
endmodule : array_model

//--- verification/tb.sv
// testbench: command sequences on the pins of the sdram command core
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
  import sdram_pkg::*;
  // ------------------------------------------------------------
  // stimulus and bookkeeping
  // ------------------------------------------------------------
  localparam int RCD_CYCLES = 4;  // row_to_column_delay rounded up to clocks
  localparam int RFC_CYCLES = 8;  // refresh_cycle_time in clocks
  localparam int XSR_CYCLES = 10; // self_refresh_exit_time in clocks
  logic                 clk_sys = 1'b0;
  logic                 resetn = 1'b0;
  logic                 cke = 1'b1;
  logic                 cs_n = 1'b1;
  logic                 ras_n = 1'b1;
  logic                 cas_n = 1'b1;
  logic                 we_n = 1'b1;
  logic [1:0]           bank_sel = 2'h0;
  logic [11:0]          addr = 12'h000;
  logic [3:0]           byte_mask = 4'h0;
  logic                 automotive_grade = 1'b0;
  logic [31:0]          array_rdata;
  logic [1:0]           array_bank;
  logic [11:0]          array_row;
  logic [7:0]           array_col;
  logic                 refresh_pulse;
  logic [11:0]          refresh_row;
  logic [11:0]          r0;
  logic [31:0]          dq_out;
  logic [3:0]           dq_oe_n;
  logic [3:0]           oe_seen;
  logic [3:0]           row_open;
  logic                 self_refresh;
  logic [31:0]          words[$];
  int                   first_at;
  int                   pulses;
  int                   n_errors = 0;
  int                   checks_done = 0;
  // free-running system clock, 5 ns period
  always #2.5 clk_sys = ~clk_sys;
  sdram_cmd_core dut (.clk_sys(clk_sys), .resetn(resetn), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr),
    .byte_mask(byte_mask), .automotive_grade(automotive_grade),
    .array_rdata(array_rdata), .array_bank(array_bank), .array_row(array_row),
    .array_col(array_col), .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .row_open(row_open), .self_refresh(self_refresh));
  array_model mem (.array_bank(array_bank), .array_row(array_row), .array_col(array_col),
    .array_rdata(array_rdata));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // one command for one clock, then deselect; the mask is set with it
  task automatic cmd(input cmd_t c, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m);
    @(negedge clk_sys);
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = c;
    bank_sel = b;
    addr = a;
    byte_mask = m;
    @(negedge clk_sys);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = CMD_NOP;
  endtask : cmd
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle
  // gathers every word driven on the data pins during a window
  task automatic capture(input int window);
    words.delete();
    first_at = -1;
    for (int i = 0; i < window; i++) begin
      @(negedge clk_sys);
      if (dq_oe_n !== 4'hF) begin
        if (first_at < 0) first_at = i;
        oe_seen = dq_oe_n;
        words.push_back(dq_out);
      end
    end
  endtask : capture
  task automatic check_words(input int off, input int n, input logic [1:0] b,
                             input logic [11:0] r, input logic [7:0] c);
    logic [7:0] col;
    for (int k = 0; k < n; k++) begin
      col = c + k[7:0];
      `CHK(words[off+k], {6'h00, b, r, col, 4'h0})
    end
  endtask : check_words
  // bounded wait for one refresh pulse
  task automatic wait_pulse();
    int i;
    for (i = 0; i < 20 && refresh_pulse !== 1'b1; i++) @(negedge clk_sys);
    if (i == 20) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no refresh pulse", $time);
      give_verdict();
    end
  endtask : wait_pulse
  // main sequence
  initial begin
    idle(6);
    resetn = 1'b1;
    `CHK({dq_oe_n, row_open, self_refresh, refresh_pulse}, 10'h3C0)
    cmd(CMD_ACTIVATE, 2'h1, 12'h123, 4'h0);
    idle(RCD_CYCLES);
    `CHK(row_open[1], 1'b1)
    `CHK(row_open, 4'h2)
    cmd(CMD_READ, 2'h1, 12'h010, 4'h0);
    capture(24);
    `CHK(words.size(), 4)
    check_words(0, 4, 2'h1, 12'h123, 8'h10);
    `CHK(first_at, 5)
    cmd(CMD_READ, 2'h1, 12'h020, 4'h0);
    cmd(CMD_TERMINATE, 2'h1, 12'h000, 4'h0);
    capture(24);
    `CHK(words.size(), 2)
    check_words(0, 2, 2'h1, 12'h123, 8'h20);
    `CHK(row_open[1], 1'b1)
    cmd(CMD_READ, 2'h1, 12'h030, 4'h0);
    cmd(CMD_READ, 2'h1, 12'h040, 4'h0);
    capture(24);
    `CHK(words.size(), 6)
    check_words(0, 2, 2'h1, 12'h123, 8'h30);
    check_words(2, 4, 2'h1, 12'h123, 8'h40);
    cmd(CMD_READ, 2'h1, 12'h050, 4'h5);
    capture(24);
    `CHK(oe_seen, 4'h5)
    `CHK(words.size(), 4)
    cmd(CMD_READ, 2'h1, 12'h050, 4'hF);
    capture(24);
    `CHK(words.size(), 0)
    // read latency two: data one clock sooner than the default
    cmd(CMD_MODE, 2'h0, 12'h022, 4'h0);
    cmd(CMD_READ, 2'h1, 12'h010, 4'h0);
    capture(24);
    `CHK(first_at, 4)
    check_words(0, 4, 2'h1, 12'h123, 8'h10);
    cmd(CMD_MODE, 2'h0, 12'h037, 4'h0);
    cmd(CMD_READ, 2'h1, 12'h0FE, 4'h0);
    idle(3);
    cmd(CMD_TERMINATE, 2'h1, 12'h000, 4'h0);
    capture(24);
    `CHK(words.size(), 5)
    check_words(0, 5, 2'h1, 12'h123, 8'hFE);
    cmd(CMD_MODE, 2'h0, 12'h032, 4'h0);
    cmd(CMD_READ, 2'h1, 12'h060, 4'h0);
    cmd(CMD_PRECHARGE, 2'h1, 12'h000, 4'h0);
    capture(24);
    `CHK(words.size(), 2)
    `CHK(row_open[1], 1'b0)
    cmd(CMD_ACTIVATE, 2'h1, 12'h2AA, 4'h0);
    idle(RCD_CYCLES);
    cmd(CMD_READ, 2'h1, 12'h408, 4'h0);
    capture(24);
    check_words(0, 4, 2'h1, 12'h2AA, 8'h08);
    `CHK(row_open[1], 1'b0)
    cmd(CMD_ACTIVATE, 2'h2, 12'h0F0, 4'h0);
    idle(RCD_CYCLES);
    cmd(CMD_READ, 2'h2, 12'h070, 4'h0);
    byte_mask = 4'hF;
    idle(1);
    cmd(CMD_WRITE, 2'h2, 12'h070, 4'h0);
    capture(24);
    `CHK(words.size(), 0)
    cmd(CMD_ACTIVATE, 2'h0, 12'h001, 4'h0);
    cmd(CMD_PRECHARGE, 2'h2, 12'h400, 4'h0);
    idle(4);
    `CHK(row_open, 4'h0)
    idle(4);
    cmd(CMD_REFRESH, 2'h0, 12'h000, 4'h0);
    wait_pulse();
    r0 = refresh_row;
    idle(RFC_CYCLES);
    cmd(CMD_REFRESH, 2'h3, 12'hFFF, 4'h0);
    wait_pulse();
    `CHK(refresh_row, r0 + 12'h001)
    idle(RFC_CYCLES);
    cke = 1'b0;
    cmd(CMD_REFRESH, 2'h0, 12'h000, 4'h0);
    idle(4);
    `CHK(self_refresh, 1'b1)
    cmd(CMD_ACTIVATE, 2'h3, 12'h001, 4'h0);
    pulses = 0;
    for (int i = 0; i < 70; i++) begin
      @(negedge clk_sys);
      if (refresh_pulse === 1'b1) pulses++;
    end
    `CHK(pulses >= 2, 1'b1)
    `CHK(row_open[3], 1'b0)
    cke = 1'b1;
    idle(XSR_CYCLES);
    `CHK(self_refresh, 1'b0)
    cmd(CMD_REFRESH, 2'h0, 12'h000, 4'h0);
    idle(RFC_CYCLES);
    automotive_grade = 1'b1;
    cke = 1'b0;
    cmd(CMD_REFRESH, 2'h0, 12'h000, 4'h0);
    idle(6);
    `CHK(self_refresh, 1'b0)
    cke = 1'b1;
    idle(4);
    give_verdict();
  end
endmodule : tb
